// *** rtl/arc_autoreclose.sv ***
// Autoreclosure supervisory state machine with shot cycle
//
// How it works
// - Initiation needs enable, breaker assigned, no blocks.
// - Standby with breaker open; never recloses there.
// - Breaker close starts manual block, then Ready.
// - Ready needs closed breaker, no initiate, no block.
// - Run entered from Ready on initiate, or from run-to-ready on a retrip.
// - Blocked while any assigned or external block is asserted, except in Lockout.
// - Listed failures all drive Lockout.
// - Lockout exits after reset input and timer.
// - Service alarms never cause Lockout.
// - Running times fault, trip moves to wait open.
// - Breaker must open within 200 ms window.
// - Dead timer only cut by block, disable, or breaker close to Lockout.
// - Reclose only if open, ready, no trips.
// - Shot counter increments in the same cycle as reclose command.
// - Reclose supervision timer starts entering Reclosing.
// - Breaker closed in Reclosing starts run-to-ready.
// - Run-to-ready expiry returns Ready, sets successful.
// - Retrip repeats shot; last shot fails to Lockout.
`timescale 1ns/1ps
module arc_autoreclose
  import arc_pkg::*;
#(
  parameter int unsigned BKR_SUPV_CYCLES = BKR_SUPV_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration and live inputs
  input wire arc_cfg_t cfg,
  input wire arc_in_t din,
  // Status and breaker command
  output arc_state_t state,
  output logic [SHOT_W-1:0] shot_count,
  output logic successful,
  output logic failed,
  output logic reclose_cmd
);

  localparam logic [TMR_W-1:0] BKR_SUPV_LOAD = TMR_W'(BKR_SUPV_CYCLES);

  arc_reg_t r_ff;
  arc_reg_t nxt_r;

  // True when a masked function set has any bit up
  function automatic logic any_sel(input logic [FN_W-1:0] sig,
                                   input logic [FN_W-1:0] msk);
    any_sel = |(sig & msk);
  endfunction : any_sel

  // Timer has run out
  function automatic logic tmr_done(input logic [TMR_W-1:0] t);
    tmr_done = (t == TMR_RST);
  endfunction : tmr_done

  logic act;
  logic blk;
  logic init_any;
  logic trip_any;
  logic cb_on_event;
  logic recl_ok;

  // Qualifying conditions
  always_comb begin
    act = cfg.enable & cfg.cb_assigned;
    blk = any_sel(din.block_fn, cfg.block_assign) |
          (|din.external_block_inputs);
    init_any = any_sel(din.init_pickup | din.init_trip, cfg.init_assign);
    trip_any = any_sel(din.init_trip, cfg.init_assign);
    cb_on_event = din.cb_closed & ~r_ff.cb_prev;
    recl_ok = ~din.cb_closed &
              (din.cb_ready | ~cfg.cb_ready_used) &
              ~init_any & ~din.general_trip;
  end

  // Next-state logic
  always_comb begin
    nxt_r = r_ff;
    nxt_r.cb_prev = din.cb_closed;
    nxt_r.reclose_cmd = 1'b0;
    if (!tmr_done(r_ff.tmr)) begin
      nxt_r.tmr = r_ff.tmr - TMR_ONE;
    end
    if (!act) begin
      nxt_r.st = ST_STANDBY;
      nxt_r.tmr = TMR_RST;
      nxt_r.lo_armed = 1'b0;
    end else if (blk && r_ff.st != ST_LOCKOUT) begin
      nxt_r.st = ST_BLOCKED;
      nxt_r.tmr = TMR_RST;
    end else begin
      unique case (r_ff.st)
        ST_STANDBY: begin
          // Wait for the breaker to be closed
          if (cb_on_event) begin
            nxt_r.st = ST_MAN_BLOCK;
            nxt_r.tmr = cfg.t_man_block;
          end
        end
        ST_MAN_BLOCK: begin
          // Trip during blocking is allowed; check breaker afterward
          if (tmr_done(r_ff.tmr)) begin
            nxt_r.st = din.cb_closed ? ST_READY : ST_STANDBY;
          end
        end
        ST_READY: begin
          if (!din.cb_closed) begin
            nxt_r.st = ST_STANDBY;
          end else if (init_any) begin
            nxt_r.st = ST_RUNNING;
            nxt_r.tmr = cfg.t_fault;
            nxt_r.shot = SHOT_RST;
            nxt_r.successful = 1'b0;
            nxt_r.failed = 1'b0;
          end
        end
        ST_RUNNING: begin
          if (din.rate_exceeded || din.breaker_fail) begin
            nxt_r.st = ST_LOCKOUT;
          end else if (trip_any) begin
            nxt_r.st = ST_WAIT_OPEN;
            nxt_r.tmr = BKR_SUPV_LOAD;
          end else if (tmr_done(r_ff.tmr)) begin
            nxt_r.st = ST_LOCKOUT;
          end
        end
        ST_WAIT_OPEN: begin
          if (!din.cb_closed) begin
            nxt_r.st = ST_DEAD;
            nxt_r.tmr = cfg.t_dead;
          end else if (tmr_done(r_ff.tmr)) begin
            nxt_r.st = ST_LOCKOUT;
          end
        end
        ST_DEAD: begin
          if (din.cb_closed) begin
            nxt_r.st = ST_LOCKOUT;
          end else if (tmr_done(r_ff.tmr)) begin
            if (recl_ok) begin
              nxt_r.st = ST_RECLOSING;
              nxt_r.shot = r_ff.shot + SHOT_ONE;
              nxt_r.reclose_cmd = 1'b1;
              nxt_r.tmr = cfg.t_recl_supv;
            end else begin
              nxt_r.st = ST_LOCKOUT;
            end
          end
        end
        ST_RECLOSING: begin
          nxt_r.reclose_cmd = ~din.cb_closed;
          if (din.cb_closed) begin
            nxt_r.st = ST_RUN2RDY;
            nxt_r.tmr = cfg.t_run2rdy;
          end else if (tmr_done(r_ff.tmr)) begin
            nxt_r.st = ST_LOCKOUT;
          end
        end
        ST_RUN2RDY: begin
          if (init_any) begin
            if (r_ff.shot >= cfg.shots) begin
              nxt_r.st = ST_LOCKOUT;
              nxt_r.failed = 1'b1;
            end else begin
              nxt_r.st = ST_RUNNING;
              nxt_r.tmr = cfg.t_fault;
            end
          end else if (!din.cb_closed) begin
            nxt_r.st = ST_LOCKOUT;
          end else if (tmr_done(r_ff.tmr)) begin
            nxt_r.st = ST_READY;
            nxt_r.successful = 1'b1;
          end
        end
        ST_BLOCKED: begin
          nxt_r.st = ST_STANDBY;
        end
        ST_LOCKOUT: begin
          // Service alarms are not inputs here at all
          if (!r_ff.lo_armed) begin
            if (din.lockout_reset) begin
              nxt_r.lo_armed = 1'b1;
              nxt_r.tmr = cfg.t_lo_reset;
            end
          end else if (tmr_done(r_ff.tmr)) begin
            nxt_r.st = ST_STANDBY;
            nxt_r.lo_armed = 1'b0;
          end
        end
        default: begin
          nxt_r.st = ST_STANDBY;
          nxt_r.tmr = TMR_RST;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_ff.st <= ST_STANDBY;
      r_ff.tmr <= TMR_RST;
      r_ff.shot <= SHOT_RST;
      r_ff.successful <= 1'b0;
      r_ff.failed <= 1'b0;
      r_ff.reclose_cmd <= 1'b0;
      r_ff.lo_armed <= 1'b0;
      r_ff.cb_prev <= 1'b0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from flops
  assign state = r_ff.st;
  assign shot_count = r_ff.shot;
  assign successful = r_ff.successful;
  assign failed = r_ff.failed;
  assign reclose_cmd = r_ff.reclose_cmd;

  default clocking cb_clk @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // No command while in Standby
  property p_standby_quiet;
    r_ff.st == ST_STANDBY |-> !reclose_cmd;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("reclose command in standby");

  // Inactive function forces Standby
  property p_inactive;
    !act |=> r_ff.st == ST_STANDBY;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("inactive function not in standby");

  // Manual block expiry with breaker closed gives Ready
  property p_man_block;
    r_ff.st == ST_MAN_BLOCK && tmr_done(r_ff.tmr) && din.cb_closed &&
    act && !blk |=> r_ff.st == ST_READY;
  endproperty
  a_man_block: assert property (p_man_block)
    else $error("manual block expiry did not reach ready");

  // Running only after Ready or a failed shot
  property p_run_entry;
    $rose(r_ff.st == ST_RUNNING) |->
      $past(r_ff.st) == ST_READY || $past(r_ff.st) == ST_RUN2RDY;
  endproperty
  a_run_entry: assert property (p_run_entry)
    else $error("running entered from wrong state");

  // Block wins outside lockout
  property p_block;
    act && blk && r_ff.st != ST_LOCKOUT |=> r_ff.st == ST_BLOCKED;
  endproperty
  a_block: assert property (p_block)
    else $error("block not honoured");

  // Dead timing starts only on breaker open
  property p_dead_entry;
    $rose(r_ff.st == ST_DEAD) |->
      $past(r_ff.st) == ST_WAIT_OPEN && !$past(din.cb_closed);
  endproperty
  a_dead_entry: assert property (p_dead_entry)
    else $error("dead timing entered wrongly");

  // Shot count already advanced with the command
  property p_shot_first;
    $rose(reclose_cmd) |->
      shot_count == $past(shot_count) + SHOT_ONE &&
      r_ff.st == ST_RECLOSING;
  endproperty
  a_shot_first: assert property (p_shot_first)
    else $error("shot count not advanced at reclose");

  // Successful flag only on return to Ready
  property p_success;
    $rose(successful) |-> r_ff.st == ST_READY &&
      $past(r_ff.st) == ST_RUN2RDY;
  endproperty
  a_success: assert property (p_success)
    else $error("successful set outside ready return");

  // Failed flag only on a retrip after the last shot
  property p_failed;
    $rose(failed) |-> r_ff.st == ST_LOCKOUT &&
      $past(r_ff.st) == ST_RUN2RDY;
  endproperty
  a_failed: assert property (p_failed)
    else $error("failed set outside last-shot lockout");

  // While active, Lockout left only after armed reset timer
  property p_lockout_exit;
    $past(r_ff.st) == ST_LOCKOUT && r_ff.st != ST_LOCKOUT && $past(act) |->
      $past(r_ff.lo_armed) && tmr_done($past(r_ff.tmr));
  endproperty
  a_lockout_exit: assert property (p_lockout_exit)
    else $error("lockout left without reset timer");

endmodule : arc_autoreclose

// *** rtl/arc_pkg.sv ***
// Package for the autoreclosure supervisory state machine
package arc_pkg;
  // Clock period and fixed breaker supervision window
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BKR_SUPV_MS = 200;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned BKR_SUPV_CYC = BKR_SUPV_MS * NS_PER_MS / CLK_PERIOD_NS;

  // Widths
  localparam int TMR_W = 32;
  localparam int SHOT_W = 4;
  localparam int FN_W = 4;
  localparam int EXB_W = 2;
  localparam logic [SHOT_W-1:0] SHOT_RST = 4'h0;
  localparam logic [SHOT_W-1:0] SHOT_ONE = 4'h1;
  localparam logic [TMR_W-1:0] TMR_RST = 32'h0;
  localparam logic [TMR_W-1:0] TMR_ONE = 32'h1;

  // One-hot states, top level and shot cycle
  typedef enum logic [9:0] {
    ST_STANDBY   = 10'h001,
    ST_MAN_BLOCK = 10'h002,
    ST_READY     = 10'h004,
    ST_RUNNING   = 10'h008,
    ST_WAIT_OPEN = 10'h010,
    ST_DEAD      = 10'h020,
    ST_RECLOSING = 10'h040,
    ST_RUN2RDY   = 10'h080,
    ST_BLOCKED   = 10'h100,
    ST_LOCKOUT   = 10'h200
  } arc_state_t;

  // Operator configuration, stable during a sequence
  typedef struct packed {
    logic enable;
    logic cb_assigned;
    logic cb_ready_used;
    logic [SHOT_W-1:0] shots;
    logic [FN_W-1:0] init_assign;
    logic [FN_W-1:0] block_assign;
    logic [TMR_W-1:0] t_man_block;
    logic [TMR_W-1:0] t_fault;
    logic [TMR_W-1:0] t_dead;
    logic [TMR_W-1:0] t_recl_supv;
    logic [TMR_W-1:0] t_run2rdy;
    logic [TMR_W-1:0] t_lo_reset;
  } arc_cfg_t;

  // Live inputs from breaker and protective functions
  typedef struct packed {
    logic cb_closed;
    logic cb_ready;
    logic [FN_W-1:0] init_pickup;
    logic [FN_W-1:0] init_trip;
    logic [FN_W-1:0] block_fn;
    logic [EXB_W-1:0] external_block_inputs;
    logic general_trip;
    logic rate_exceeded;
    logic breaker_fail;
    logic lockout_reset;
  } arc_in_t;

  // Whole module state
  typedef struct packed {
    arc_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [SHOT_W-1:0] shot;
    logic successful;
    logic failed;
    logic reclose_cmd;
    logic lo_armed;
    logic cb_prev;
  } arc_reg_t;
endpackage : arc_pkg

// *** sim/arc_breaker_model.sv ***
// Breaker model: opens on a protection trip, closes on command
`timescale 1ns/1ps
module arc_breaker_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Requests
  input wire logic trip,
  input wire logic close_cmd,
  input wire logic man_close,
  input wire logic jam,
  // Breaker position
  output logic cb_closed,
  output logic cb_ready
);
  logic [3:0] cnt_ff;
  // Manual close at once; trip or close command: operating delay, then the contacts change over
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 4'h0;
      cb_closed <= 1'b0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h1) begin
        cb_closed <= ~cb_closed;
      end
    end else if (man_close) begin
      cb_closed <= 1'b1;
    end else if (trip && cb_closed && !jam) begin
      cnt_ff <= 4'(DLY);
    end else if (close_cmd && !cb_closed) begin
      cnt_ff <= 4'(DLY);
    end
  end
  // Not ready while operating
  assign cb_ready = (cnt_ff == 4'h0);
endmodule : arc_breaker_model

// *** sim/tb_arc_autoreclose.sv ***
// Testbench for the autoreclosure state machine
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_arc_autoreclose;
  import arc_pkg::*;
  localparam int SUPV = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  arc_cfg_t cfg;
  arc_in_t drv;
  arc_in_t din;
  arc_state_t state;
  logic [SHOT_W-1:0] shot_count;
  logic successful, failed, reclose_cmd, cb_closed, cb_ready;
  logic man_close = 1'b0;
  logic jam = 1'b0;
  int bad_count = 0;
  int n_compared = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Breaker position merged into live inputs
  always_comb begin
    din = drv;
    din.cb_closed = cb_closed;
    din.cb_ready = cb_ready;
  end

  arc_autoreclose #(.BKR_SUPV_CYCLES(SUPV)) arc_autoreclose_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .din(din),
    .state(state), .shot_count(shot_count), .successful(successful),
    .failed(failed), .reclose_cmd(reclose_cmd));

  arc_breaker_model arc_breaker_model_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .trip(|drv.init_trip),
    .close_cmd(reclose_cmd), .man_close(man_close), .jam(jam),
    .cb_closed(cb_closed), .cb_ready(cb_ready));

  // Verdict and end of run
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Bounded wait for a state
  task automatic wait_st(input arc_state_t s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (state === s) return;
    end
    bad_count++;
    $display("MISMATCH t=%0t got %h exp %h", $time, state, s);
    final_report();
  endtask : wait_st

  // Drive the trip inputs
  task automatic set_trip(input logic v);
    @(posedge ref_clk);
    drv.init_trip <= {3'h0, v};
  endtask : set_trip

  // One shot from a trip to run-to-ready; exp 0 skips the count check
  task automatic do_shot(input logic [SHOT_W-1:0] exp);
    set_trip(1'b1);
    wait_st(ST_RUNNING, 4);
    wait_st(ST_WAIT_OPEN, 4);
    wait_st(ST_DEAD, 8);
    set_trip(1'b0);
    wait_st(ST_RECLOSING, 10);
    `CHK(reclose_cmd, 1'b1)
    if (exp != 4'h0) `CHK(shot_count, exp)
    wait_st(ST_RUN2RDY, 8);
    `CHK(reclose_cmd, 1'b0)
  endtask : do_shot

  // Manual close from Standby through the blocking time
  task automatic go_ready();
    @(posedge ref_clk);
    man_close <= 1'b1;
    @(posedge ref_clk);
    man_close <= 1'b0;
    wait_st(ST_MAN_BLOCK, 4);
    wait_st(ST_READY, 7);
  endtask : go_ready

  initial begin
    // Initiator trips only, settings held for the whole run except enable, switched off after the stuck test
    cfg = '{enable: 1'b1, cb_assigned: 1'b1, cb_ready_used: 1'b1,
      shots: 4'h2, init_assign: 4'h1, block_assign: 4'h2,
      t_man_block: 32'h3, t_fault: 32'h1e, t_dead: 32'h5,
      t_recl_supv: 32'h8, t_run2rdy: 32'ha, t_lo_reset: 32'h4};
    drv = '0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    `CHK(state, ST_STANDBY)
    `CHK({shot_count, successful, failed}, 6'h00)
    // Block and release in Standby
    @(posedge ref_clk);
    drv.external_block_inputs <= 2'h1;
    wait_st(ST_BLOCKED, 3);
    `CHK(reclose_cmd, 1'b0)
    @(posedge ref_clk);
    drv.external_block_inputs <= 2'h0;
    wait_st(ST_STANDBY, 3);
    // Masked block functions: only assigned ones count
    @(posedge ref_clk);
    drv.block_fn <= 4'h3;
    wait_st(ST_BLOCKED, 3);
    @(posedge ref_clk);
    drv.block_fn <= 4'h1;
    wait_st(ST_STANDBY, 3);
    $display("test block done");
    // Permanent fault: two shots then Lockout
    go_ready();
    do_shot(4'h1);
    do_shot(4'h2);
    set_trip(1'b1);
    wait_st(ST_LOCKOUT, 4);
    `CHK(failed, 1'b1)
    set_trip(1'b0);
    @(posedge ref_clk);
    drv.lockout_reset <= 1'b1;
    @(posedge ref_clk);
    drv.lockout_reset <= 1'b0;
    wait_st(ST_STANDBY, 8);
    $display("test lockout done");
    // Transient fault: one shot then Ready
    go_ready();
    do_shot(4'h1);
    wait_st(ST_READY, 14);
    `CHK(successful, 1'b1)
    $display("test success done");
    // Reset in mid-run clears count and flags
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    `CHK(state, ST_STANDBY)
    `CHK({shot_count, successful, failed}, 6'h00)
    $display("test reset done");
    // Breaker stuck closed
    go_ready();
    @(posedge ref_clk);
    jam <= 1'b1;
    set_trip(1'b1);
    wait_st(ST_WAIT_OPEN, 6);
    wait_st(ST_LOCKOUT, SUPV + 3);
    `CHK(reclose_cmd, 1'b0)
    $display("test stuck done");
    // Function switched off leaves Lockout for Standby
    @(posedge ref_clk);
    cfg.enable <= 1'b0;
    wait_st(ST_STANDBY, 3);
    @(posedge ref_clk);
    cfg.enable <= 1'b1;
    jam <= 1'b0;
    set_trip(1'b0);
    repeat (4) @(posedge ref_clk);
    $display("test disable done");
    // General trip at dead expiry refuses the reclose
    go_ready();
    set_trip(1'b1);
    wait_st(ST_DEAD, 12);
    @(posedge ref_clk);
    drv.init_trip <= 4'h0;
    drv.general_trip <= 1'b1;
    wait_st(ST_LOCKOUT, 10);
    `CHK({reclose_cmd, shot_count}, 5'h00)
    $display("test inhibit done");
    final_report();
  end
endmodule : tb_arc_autoreclose
